// ### verilog/iox_defs.vh
// Purpose: Constants for the increment and inclusive-OR instruction execute block.
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses.
// Notes: Opcode values are compared against instruction bits 13:8.
// Overview of operation
// - increment_register adds one to file register; d picks accumulator or file.
// - increment_skip_if_zero adds one, writes destination, leaves zero flag alone.
// - Nonzero skip result lets the next instruction execute normally.
// - Zero skip result replaces next instruction with a four-phase no-op cycle.
// - or_literal_into_accumulator ORs accumulator with literal, writes accumulator, sets zero.
// - or_accumulator_with_register ORs accumulator with file; d picks destination.
// - Phases: decode, read operand, process data, write destination.
`ifndef IOX_DEFS_VH
`define IOX_DEFS_VH
`define IOX_OP_INC 6'h0A
`define IOX_OP_INCSKIP 6'h0F
`define IOX_OP_ORLIT 6'h38
`define IOX_OP_ORREG 6'h04
`define IOX_OP_MSB 13
`define IOX_OP_LSB 8
`define IOX_D_BIT 7
`define IOX_ADDR_MSB 6
`define IOX_LIT_MSB 7
`define IOX_ACC_RESET 8'h00
`define IOX_ZERO_RESET 1'b0
`endif

// ### verilog/iox_alu.v
// Purpose: Combinational result path for increment and inclusive OR.
// Assumes: Operands are stable during the process phase.
// Notes: Zero detect covers the 8-bit wrapped result.
`timescale 1ns/1ns
module iox_alu
(
  // Operands
  input wire [7:0] acc,
  input wire [7:0] operand,
  input wire do_or,
  // Result
  output wire [7:0] result,
  output wire is_zero
);
  wire [7:0] inc_val;
  assign inc_val = operand + 8'h01;
  assign result = do_or ? (acc | operand) : inc_val;
  assign is_zero = (result == 8'h00);
endmodule // iox_alu

// ### verilog/iox_exec.v
// Purpose: Decode and execute increment and inclusive-OR instructions over four phases.
// Assumes: instr_valid is held with a stable instruction through the whole cycle.
// Notes: The file register is read in phase 2 and written in phase 4.
`timescale 1ns/1ns
`include "iox_defs.vh"
module iox_exec
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Instruction input
  input wire [13:0] instr,
  input wire instr_valid,
  // File register read port
  input wire [7:0] file_rdata,
  output reg [6:0] file_addr_r,
  output reg file_rd_r,
  // File register write port
  output reg [7:0] file_wdata_r,
  output reg file_we_r,
  // Architectural state
  output reg [7:0] acc_r,
  output reg zero_r,
  // Phase and skip status
  output reg [3:0] phase_r,
  output reg nop_cycle_r,
  output reg busy_r
);
  localparam S_Q1 = 4'h1;
  localparam S_Q2 = 4'h2;
  localparam S_Q3 = 4'h4;
  localparam S_Q4 = 4'h8;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [1:0] kind_r;
  reg dest_r;
  reg known_r;
  reg [7:0] operand_r;
  reg skip_pend_r;
  reg [1:0] kind_nxt;
  reg known_nxt;
  reg [7:0] acc_nxt;
  reg zero_nxt;
  reg wr_file_nxt;
  reg skip_nxt;
  wire [5:0] op;
  wire [7:0] alu_res;
  wire alu_zero;
  wire start;
  assign op = instr[`IOX_OP_MSB:`IOX_OP_LSB];
  // A cycle starts on a presented instruction or on a pending skip.
  assign start = instr_valid || skip_pend_r;
  iox_alu u_alu
  (
    .acc(acc_r),
    .operand(operand_r),
    .do_or(kind_r[1]),
    .result(alu_res),
    .is_zero(alu_zero)
  );
  always @*
  begin
    case (state_r)
      S_Q1: state_nxt = (instr_valid || skip_pend_r) ? S_Q2 : S_Q1;
      S_Q2: state_nxt = S_Q3;
      S_Q3: state_nxt = S_Q4;
      S_Q4: state_nxt = S_Q1;
      default: state_nxt = S_Q1;
    endcase
  end
  // Opcode decode; kind 00 inc, 01 inc-skip, 10 or-literal, 11 or-register.
  always @*
  begin
    kind_nxt = 2'b00;
    known_nxt = 1'b1;
    case (op)
      `IOX_OP_INC:
      begin
        kind_nxt = 2'b00;
      end
      `IOX_OP_INCSKIP:
      begin
        kind_nxt = 2'b01;
      end
      `IOX_OP_ORLIT:
      begin
        kind_nxt = 2'b10;
      end
      `IOX_OP_ORREG:
      begin
        kind_nxt = 2'b11;
      end
      default:
      begin
        known_nxt = 1'b0;
      end
    endcase
  end
  // Write-back values, taken at the end of the write phase.
  always @*
  begin
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    wr_file_nxt = 1'b0;
    skip_nxt = 1'b0;
    if (known_r)
    begin
      if (kind_r == 2'b10 || !dest_r)
      begin
        acc_nxt = alu_res;
      end
      else
      begin
        wr_file_nxt = 1'b1;
      end
      if (kind_r != 2'b01)
      begin
        zero_nxt = alu_zero;
      end
      skip_nxt = (kind_r == 2'b01) && alu_zero;
    end
  end
  // Phase register; the status port shows the phase one cycle late.
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= S_Q1;
      phase_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= (state_r == S_Q1 && !start) ? 4'h0 : state_r;
    end
  end
  // Per-phase work of the instruction cycle.
  always @(posedge clk)
  begin
    if (reset)
    begin
      kind_r <= 2'b00;
      dest_r <= 1'b0;
      known_r <= 1'b0;
      operand_r <= 8'h00;
      skip_pend_r <= 1'b0;
      file_addr_r <= 7'h00;
      file_rd_r <= 1'b0;
      file_wdata_r <= 8'h00;
      file_we_r <= 1'b0;
      acc_r <= `IOX_ACC_RESET;
      zero_r <= `IOX_ZERO_RESET;
      nop_cycle_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      file_rd_r <= 1'b0;
      file_we_r <= 1'b0;
      case (state_r)
        S_Q1:
        begin
          // Decode phase; a pending skip turns this cycle into a no-op.
          if (skip_pend_r)
          begin
            skip_pend_r <= 1'b0;
            nop_cycle_r <= 1'b1;
            known_r <= 1'b0;
            busy_r <= 1'b1;
          end
          else if (instr_valid)
          begin
            busy_r <= 1'b1;
            nop_cycle_r <= 1'b0;
            dest_r <= instr[`IOX_D_BIT];
            file_addr_r <= instr[`IOX_ADDR_MSB:0];
            kind_r <= kind_nxt;
            known_r <= known_nxt;
          end
          else
          begin
            busy_r <= 1'b0;
            nop_cycle_r <= 1'b0;
          end
        end
        S_Q2:
        begin
          // Operand read: literal from the word, otherwise the file register.
          if (known_r && kind_r == 2'b10)
          begin
            operand_r <= instr[`IOX_LIT_MSB:0];
          end
          else if (known_r)
          begin
            file_rd_r <= 1'b1;
          end
        end
        S_Q3:
        begin
          // File data is captured while the read pulse stands.
          if (known_r && kind_r != 2'b10)
          begin
            operand_r <= file_rdata;
          end
        end
        S_Q4:
        begin
          // Write phase.
          busy_r <= 1'b0;
          acc_r <= acc_nxt;
          zero_r <= zero_nxt;
          skip_pend_r <= skip_nxt;
          file_we_r <= wr_file_nxt;
          if (wr_file_nxt)
          begin
            file_wdata_r <= alu_res;
          end
        end
        default:
        begin
          busy_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // iox_exec

// ### verif/iox_file_model.sv
// Purpose: File register array facing the execute block.
// Assumes: Read data is due while the read pulse stands.
// Notes: Outside the read pulse the data bus shows the inverse of the word.
`timescale 1ns/1ns
module iox_file_model
(
  // Clock
  input wire clk,
  // File port
  input wire [6:0] addr,
  input wire rd,
  input wire we,
  input wire [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:127];
  always_comb
    rdata = rd ? mem[addr] : ~mem[addr];
  always @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
  end
endmodule // iox_file_model

// ### verif/iox_exec_chk.sv
// Purpose: Port assertions for the execute block.
// Assumes: Synchronous active-high reset.
// Notes: Bound from the testbench file.
`timescale 1ns/1ns
module iox_exec_chk
(
  // Watched ports
  input wire clk,
  input wire reset,
  input wire [13:0] instr,
  input wire file_rd_r,
  input wire file_we_r,
  input wire zero_r,
  input wire [3:0] phase_r,
  input wire nop_cycle_r,
  input wire busy_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence rest_s;
    phase_r == 4'h2 ##1 phase_r == 4'h4 ##1 phase_r == 4'h8;
  endsequence
  sequence nop_run_s;
    nop_cycle_r [*4] ##1 !nop_cycle_r;
  endsequence
  sequence busy_run_s;
    phase_r == 4'h1 ##3 $fell(busy_r);
  endsequence
  phase_hot_a: assert property ($onehot0(phase_r))
    else $error("phase not one-hot");
  phase_seq_a: assert property (phase_r == 4'h1 |=> rest_s)
    else $error("phase order wrong");
  rd_pulse_a: assert property (file_rd_r |=> !file_rd_r)
    else $error("read pulse too long");
  we_pulse_a: assert property (file_we_r |=> !file_we_r)
    else $error("write pulse too long");
  nop_len_a: assert property ($rose(nop_cycle_r) |-> nop_run_s)
    else $error("skip cycle length wrong");
  nop_quiet_a: assert property (nop_cycle_r && $past(nop_cycle_r) |-> !file_we_r && !file_rd_r)
    else $error("activity in skip cycle");
  skip_flag_a: assert property (busy_r && instr[13:8] == 6'h0F |=> $stable(zero_r))
    else $error("skip changed zero flag");
  zero_cause_a: assert property ($changed(zero_r) |-> $past(busy_r))
    else $error("zero flag changed while idle");
  busy_span_a: assert property ($rose(busy_r) |-> busy_run_s)
    else $error("busy span wrong");
endmodule // iox_exec_chk

// ### verif/testbench.sv
// Purpose: Directed test of the execute block.
// Assumes: File model answers in the same cycle as the read pulse.
// Notes: Each task judges its own results.
`timescale 1ns/1ns
module testbench;
  logic clk = 0, reset = 1, instr_valid = 0, nop_seen;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata, file_wdata_r, acc_r;
  logic [6:0] file_addr_r;
  logic file_rd_r, file_we_r, zero_r, nop_cycle_r, busy_r;
  logic [3:0] phase_r;
  int mismatches = 0, n_compared = 0, cycles = 0;
  iox_exec iox_exec_i (.*);
  iox_file_model iox_file_model_i (.clk, .addr(file_addr_r), .rd(file_rd_r),
    .we(file_we_r), .wdata(file_wdata_r), .rdata(file_rdata));
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 400)
    begin
      mismatches++;
      final_report;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic run(input logic [13:0] i);
    @(posedge clk);
    instr <= i;
    instr_valid <= 1'b1;
    nop_seen = 1'b0;
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (12) @(negedge clk) nop_seen |= nop_cycle_r;
  endtask
  task t_inc;
    chk(acc_r, 8'h00);
    iox_file_model_i.mem[5] = 8'hFF;
    run(14'h0A85);
    chk(iox_file_model_i.mem[5], 8'h00);
    chk({7'h00, zero_r}, 8'h01);
    run(14'h0A05);
    chk(acc_r, 8'h01);
    chk({7'h00, zero_r}, 8'h00);
  endtask
  task t_skip;
    iox_file_model_i.mem[6] = 8'hFF;
    run(14'h0F86);
    chk(iox_file_model_i.mem[6], 8'h00);
    chk({6'h00, nop_seen, zero_r}, 8'h02);
    iox_file_model_i.mem[6] = 8'h41;
    run(14'h0F06);
    chk({nop_seen, acc_r[6:0]}, 8'h42);
  endtask
  task t_orlit;
    iox_file_model_i.mem[5] = 8'hFF;
    run(14'h0A85);
    run(14'h3834);
    chk(acc_r, 8'h76);
    chk({7'h00, zero_r}, 8'h00);
    run(14'h3F55);
    chk(acc_r, 8'h76);
  endtask
  task t_orreg;
    iox_file_model_i.mem[127] = 8'h13;
    run(14'h04FF);
    chk(iox_file_model_i.mem[127], 8'h77);
    run(14'h047F);
    chk(acc_r, 8'h77);
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_inc;
    t_skip;
    t_orlit;
    t_orreg;
    final_report;
  end
endmodule // testbench
bind iox_exec iox_exec_chk iox_exec_chk_i (.*);
